// file: hdl/jlp_pkg.sv
package jlp_pkg;

  localparam int jlp_ports = 3;

  // Bridge controller states.
  typedef enum logic [3:0] {
    tlr, rti, sel_dr, cap_dr, sh_dr, ex1_dr, pa_dr, ex2_dr, up_dr,
    sel_ir, cap_ir, sh_ir, ex1_ir, pa_ir, ex2_ir, up_ir
  } jlp_tap_type;

  // Local port park and synchronisation states.
  typedef enum logic [3:0] {
    pk_tlr, pk_rti, pk_pdr, pk_pir, wt_rti, wt_pdr, wt_pir,
    pk_active, go_pause
  } jlp_park_type;

  // Instruction codes.
  localparam logic [7:0] idcode_instr = 8'haa;
  localparam logic [7:0] bypass_instr = 8'hff;
  localparam logic [7:0] mode_select_instr = 8'h8e;
  localparam logic [7:0] group_select_instr = 8'h03;
  localparam logic [7:0] signature_select_instr = 8'h0c;
  localparam logic [7:0] counter_select_instr = 8'h0d;
  localparam logic [7:0] counter_enable_instr = 8'h0e;
  localparam logic [7:0] counter_disable_instr = 8'h0f;
  localparam logic [7:0] park_idle_instr = 8'h84;
  localparam logic [7:0] park_reset_instr = 8'h85;
  localparam logic [7:0] park_pause_instr = 8'h86;
  localparam logic [7:0] unpark_instr = 8'h87;
  localparam logic [7:0] local_soft_reset_instr = 8'h88;

  // Reset values and capture constants.
  localparam logic [1:0] multicast_group_reset = 2'h0;
  localparam logic [7:0] instruction_reg_reset = 8'haa;
  localparam logic [7:0] chain_mode_reset = 8'h01;
  localparam logic [15:0] signature_compactor_reset = 16'h0000;
  localparam logic [31:0] test_clock_countdown_reset = 32'h00000000;
  localparam logic [7:0] ir_capture = 8'h01;

  // Mode register fields.
  localparam logic [7:0] mode_write_mask = 8'h1f;
  localparam int mode_stop_bit = 3;
  localparam int mode_loop_bit = 4;
  localparam int mode_done_bit = 7;

  localparam logic [2:0] tms_reset_pulses = 3'h5;

  typedef struct packed {
    logic backplane_test_clock;
    logic backplane_mode_select;
    logic backplane_tdi;
    logic test_reset_n;
    logic [jlp_ports-1:0] local_tdo_in;
  } jlp_pins_type;

  typedef struct packed {
    logic local_test_clock;
    logic local_mode_select;
    logic local_tdi_out;
  } jlp_lport_type;

endpackage : jlp_pkg

// file: hdl/jlp_bridge.sv
// Function
// - Mode bit 7 shows counter terminal count.
// - Self test starts edge after Update-DR.
// - Five high mode-select pulses or pin reset.
// - Level-one reset parks all ports, inits registers.
// - Register reset values AA, 01, zeros.
// - Soft reset drives all local mode-selects high.
// - Park-in-reset resets port; others unpark first.
// - Idle ports parked in one of four states.
// - Reset park drives high, others low.
// - Unparked port activates at its sync state.
// - Reset-parked port goes low on falling edge.
// - Local mode-select follows backplane after idle.
// - Ports synchronise independently; pause waits for pause.
// - Mode bits 0-2 pick chain at unpark.
// - Bit 4 loopback; pad after each port.
// - Terminal count stops parked local clocks low.
// - Bit 3 stops parked local clocks.
module jlp_bridge #(
  parameter logic [31:0] id_code = 32'h00000001
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Backplane and local pins.
  input wire jlp_pkg::jlp_pins_type pins,
  output logic tdob,
  output logic tdob_oe_n,
  output wire jlp_pkg::jlp_lport_type [jlp_pkg::jlp_ports-1:0] lport
);
  import jlp_pkg::*;

  // The value of id_code is arbitrary.

  function automatic jlp_tap_type tap_next(jlp_tap_type s, logic m);
    case (s)
      tlr: tap_next = m ? tlr : rti;
      rti: tap_next = m ? sel_dr : rti;
      sel_dr: tap_next = m ? sel_ir : cap_dr;
      cap_dr: tap_next = m ? ex1_dr : sh_dr;
      sh_dr: tap_next = m ? ex1_dr : sh_dr;
      ex1_dr: tap_next = m ? up_dr : pa_dr;
      pa_dr: tap_next = m ? ex2_dr : pa_dr;
      ex2_dr: tap_next = m ? up_dr : sh_dr;
      up_dr: tap_next = m ? sel_dr : rti;
      sel_ir: tap_next = m ? tlr : cap_ir;
      cap_ir: tap_next = m ? ex1_ir : sh_ir;
      sh_ir: tap_next = m ? ex1_ir : sh_ir;
      ex1_ir: tap_next = m ? up_ir : pa_ir;
      pa_ir: tap_next = m ? ex2_ir : pa_ir;
      ex2_ir: tap_next = m ? up_ir : sh_ir;
      up_ir: tap_next = m ? sel_dr : rti;
      default: tap_next = tlr;
    endcase
  endfunction : tap_next

  function automatic logic is_parked(jlp_park_type s);
    is_parked = (s != pk_active) && (s != go_pause);
  endfunction : is_parked

  function automatic logic [5:0] dr_len(logic [7:0] code);
    case (code)
      mode_select_instr: dr_len = 6'h08;
      group_select_instr: dr_len = 6'h02;
      signature_select_instr: dr_len = 6'h10;
      counter_select_instr, idcode_instr: dr_len = 6'h20;
      default: dr_len = 6'h01;
    endcase
  endfunction : dr_len

  //////////////////////////////////////////////////////////////////////
  jlp_pins_type pins_m;
  jlp_pins_type pins_s;
  logic tck_d;
  logic rise;
  logic fall;
  jlp_tap_type tap;
  jlp_tap_type next_tap;
  logic lvl1;
  logic [2:0] hi_cnt;

  // The first stage is read by the second stage only.
  always_ff @(posedge ref_clk) begin
    pins_m <= pins;
    pins_s <= pins_m;
  end

  // Cleared to the idle low level so no false edge follows reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= pins_s.backplane_test_clock;
    end
  end

  assign rise = pins_s.backplane_test_clock & ~tck_d;
  assign fall = ~pins_s.backplane_test_clock & tck_d;
  assign next_tap = tap_next(tap, pins_s.backplane_mode_select);
  assign lvl1 = rst | ~pins_s.test_reset_n | (tap == tlr);

  always_ff @(posedge ref_clk) begin
    if (rst || !pins_s.test_reset_n) begin
      tap <= tlr;
    end else if (rise) begin
      tap <= next_tap;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hi_cnt <= 3'h0;
    end else if (rise) begin
      if (!pins_s.backplane_mode_select) begin
        hi_cnt <= 3'h0;
      end else if (hi_cnt != tms_reset_pulses) begin
        hi_cnt <= hi_cnt + 3'h1;
      end
    end
  end

  a_tms_five_reset: assert property (@(posedge ref_clk) disable iff (rst)
    (hi_cnt == tms_reset_pulses) |-> (tap == tlr))
    else $error("controller not in reset after five high pulses");

  //////////////////////////////////////////////////////////////////////
  logic [7:0] instruction_reg;
  logic [7:0] ir_sh;
  logic [31:0] dr_sh;
  logic [7:0] chain_mode;
  logic [1:0] multicast_group;
  logic [15:0] signature_compactor;
  logic [31:0] test_clock_countdown;
  logic cnt_on;
  logic cnt_arm;
  logic cnt_done;
  logic dec_en;
  logic [jlp_ports-1:0] parked;

  assign cnt_done = cnt_on && (test_clock_countdown == 32'h0);
  assign dec_en = cnt_on && cnt_arm && !cnt_done && (|parked);

  always_ff @(posedge ref_clk) begin
    if (lvl1) begin
      instruction_reg <= instruction_reg_reset;
      ir_sh <= instruction_reg_reset;
    end else if (rise) begin
      case (tap)
        cap_ir: ir_sh <= ir_capture;
        sh_ir: ir_sh <= {pins_s.backplane_tdi, ir_sh[7:1]};
        up_ir: instruction_reg <= ir_sh;
        default: ir_sh <= ir_sh;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (lvl1) begin
      dr_sh <= 32'h0;
    end else if (rise && tap == cap_dr) begin
      case (instruction_reg)
        mode_select_instr: dr_sh <= {24'h0, cnt_done, chain_mode[6:0]};
        group_select_instr: dr_sh <= {30'h0, multicast_group};
        signature_select_instr: dr_sh <= {16'h0, signature_compactor};
        counter_select_instr: dr_sh <= test_clock_countdown;
        idcode_instr: dr_sh <= id_code;
        default: dr_sh <= 32'h0;
      endcase
    end else if (rise && tap == sh_dr) begin
      dr_sh <= (dr_sh >> 1) | ({31'h0, pins_s.backplane_tdi}
        << (dr_len(instruction_reg) - 6'h01));
    end
  end

  a_done_bit_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (rise && !lvl1 && tap == cap_dr && cnt_done
      && instruction_reg == mode_select_instr) |=> dr_sh[mode_done_bit])
    else $error("mode bit 7 not set at terminal count");

  always_ff @(posedge ref_clk) begin
    if (lvl1) begin
      chain_mode <= chain_mode_reset;
      multicast_group <= multicast_group_reset;
      signature_compactor <= signature_compactor_reset;
    end else if (rise && tap == up_dr) begin
      case (instruction_reg)
        mode_select_instr: chain_mode <= dr_sh[7:0] & mode_write_mask;
        group_select_instr: multicast_group <= dr_sh[1:0];
        signature_select_instr: signature_compactor <= dr_sh[15:0];
        default: chain_mode <= chain_mode;
      endcase
    end
  end

  a_level1_values: assert property (@(posedge ref_clk) disable iff (rst)
    (!pins_s.test_reset_n) |=> (instruction_reg == instruction_reg_reset)
      && (chain_mode == chain_mode_reset)
      && (test_clock_countdown == test_clock_countdown_reset))
    else $error("registers not initialised by level one reset");

  // Self test runs only after the count has been loaded, so a stale
  // count left by an earlier run does not start on its own.
  always_ff @(posedge ref_clk) begin
    if (lvl1) begin
      test_clock_countdown <= test_clock_countdown_reset;
      cnt_on <= 1'b0;
      cnt_arm <= 1'b0;
    end else if (rise) begin
      if (tap == up_ir && ir_sh == counter_enable_instr) begin
        cnt_on <= 1'b1;
      end
      if (tap == up_ir && ir_sh == counter_disable_instr) begin
        cnt_on <= 1'b0;
        cnt_arm <= 1'b0;
      end
      if (tap == up_dr && instruction_reg == counter_select_instr) begin
        test_clock_countdown <= dr_sh;
        cnt_arm <= 1'b1;
      end else if (dec_en) begin
        test_clock_countdown <= test_clock_countdown - 32'h1;
      end
    end
  end

  a_start_after_upd: assert property (@(posedge ref_clk) disable iff (lvl1)
    (rise && tap == up_dr && instruction_reg == counter_select_instr)
      |=> cnt_arm)
    else $error("self test not armed after update");

  a_count_step: assert property (@(posedge ref_clk) disable iff (lvl1)
    (rise && dec_en && tap != up_dr && tap != up_ir) |=>
      (test_clock_countdown == $past(test_clock_countdown) - 32'h1))
    else $error("counter did not step by one");

  //////////////////////////////////////////////////////////////////////
  jlp_park_type pst [jlp_ports];
  logic [jlp_ports-1:0] run_q;
  logic [jlp_ports-1:0] tck_q;
  logic [jlp_ports-1:0] tms_q;
  logic [jlp_ports-1:0] tdo_q;
  logic [jlp_ports-1:0] pad;
  logic [jlp_ports-1:0] src;
  logic chain_out;

  // Pads follow each inserted port; loopback never inserts one.
  always_comb begin
    chain_out = (tap == sh_ir) ? ir_sh[0] : dr_sh[0];
    for (int i = 0; i < jlp_ports; i++) begin
      src[i] = chain_out;
      if (!parked[i]) begin
        chain_out = pad[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tdob <= 1'b0;
      tdob_oe_n <= 1'b1;
    end else if (fall) begin
      tdob <= chain_out;
      tdob_oe_n <= !(tap == sh_dr || tap == sh_ir);
    end
  end

  for (genvar i = 0; i < jlp_ports; i++) begin : g_port
    logic pick;
    assign pick = chain_mode[i] && !chain_mode[mode_loop_bit];
    assign parked[i] = is_parked(pst[i]);

    always_ff @(posedge ref_clk) begin
      if (lvl1) begin
        pst[i] <= pk_tlr;
      end else if (rise && tap == up_ir) begin
        case (ir_sh)
          local_soft_reset_instr: pst[i] <= pk_tlr;
          park_reset_instr: begin
            if (pst[i] == pk_active || pst[i] == pk_tlr) begin
              pst[i] <= pk_tlr;
            end
          end
          park_idle_instr: begin
            if (!parked[i]) begin
              pst[i] <= pk_rti;
            end
          end
          park_pause_instr: begin
            if (pst[i] == pk_active) begin
              pst[i] <= go_pause;
            end
          end
          unpark_instr: begin
            if (pick && (pst[i] == pk_tlr || pst[i] == pk_rti)) begin
              pst[i] <= wt_rti;
            end else if (pick && pst[i] == pk_pdr) begin
              pst[i] <= wt_pdr;
            end else if (pick && pst[i] == pk_pir) begin
              pst[i] <= wt_pir;
            end
          end
          default: pst[i] <= pst[i];
        endcase
      end else if (rise) begin
        case (pst[i])
          wt_rti: if (next_tap == rti) pst[i] <= pk_active;
          wt_pdr: if (next_tap == pa_dr) pst[i] <= pk_active;
          wt_pir: if (next_tap == pa_ir) pst[i] <= pk_active;
          go_pause: begin
            if (next_tap == pa_dr) begin
              pst[i] <= pk_pdr;
            end else if (next_tap == pa_ir) begin
              pst[i] <= pk_pir;
            end
          end
          default: pst[i] <= pst[i];
        endcase
      end
    end

    // Outside level-one reset, mode select and the enable of the local clock
    // change only on the falling backplane edge, so a local high phase is never cut short.
    always_ff @(posedge ref_clk) begin
      if (lvl1) begin
        tms_q[i] <= 1'b1;
        run_q[i] <= 1'b1;
        tdo_q[i] <= 1'b0;
      end else if (fall) begin
        if (pst[i] == pk_tlr) begin
          tms_q[i] <= 1'b1;
        end else if (parked[i]) begin
          tms_q[i] <= 1'b0;
        end else begin
          tms_q[i] <= pins_s.backplane_mode_select;
        end
        run_q[i] <= !(parked[i] && chain_mode[mode_stop_bit])
          && !(parked[i] && cnt_done);
        tdo_q[i] <= src[i];
      end
    end

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        tck_q[i] <= 1'b0;
        pad[i] <= 1'b0;
      end else begin
        tck_q[i] <= pins_s.backplane_test_clock && run_q[i];
        if (rise) begin
          pad[i] <= pins_s.local_tdo_in[i];
        end
      end
    end

    assign lport[i].local_test_clock = tck_q[i];
    assign lport[i].local_mode_select = tms_q[i];
    assign lport[i].local_tdi_out = tdo_q[i];
  end

  a_reset_park_high: assert property (@(posedge ref_clk) disable iff (lvl1)
    (fall && pst[0] == pk_tlr) |=> lport[0].local_mode_select)
    else $error("reset parked port not held high");

  a_idle_park_low: assert property (@(posedge ref_clk) disable iff (lvl1)
    (fall && pst[0] == pk_rti) |=> !lport[0].local_mode_select)
    else $error("idle parked port not held low");

  a_sync_at_idle: assert property (@(posedge ref_clk) disable iff (lvl1)
    (rise && tap != up_ir && pst[0] == wt_rti && next_tap == rti)
      |=> (pst[0] == pk_active))
    else $error("port not active after idle sync");

  a_pause_waits: assert property (@(posedge ref_clk) disable iff (lvl1)
    (rise && tap != up_ir && pst[0] == wt_pdr && next_tap != pa_dr)
      |=> (pst[0] == wt_pdr))
    else $error("pause parked port joined early");

  a_stop_clock_low: assert property (@(posedge ref_clk) disable iff (lvl1)
    (fall && parked[0] && cnt_done) |=> ##1 !lport[0].local_test_clock
      )
    else $error("local clock running after terminal count");

endmodule : jlp_bridge

// file: testbench/jlp_chain_model.sv
module jlp_chain_model (
  // Local port pins.
  input wire logic tck_l,
  input wire logic tms_l,
  input wire logic tdi_l,
  output logic tdo,
  // Observed local controller state.
  output jlp_pkg::jlp_tap_type state
);
  timeunit 1ns;
  timeprecision 100ps;
  import jlp_pkg::*;

  logic q = 1'b0;

  function automatic jlp_tap_type nx(jlp_tap_type s, logic m);
    case (s)
      tlr: nx = m ? tlr : rti;
      rti: nx = m ? sel_dr : rti;
      sel_dr: nx = m ? sel_ir : cap_dr;
      cap_dr: nx = m ? ex1_dr : sh_dr;
      sh_dr: nx = m ? ex1_dr : sh_dr;
      ex1_dr: nx = m ? up_dr : pa_dr;
      pa_dr: nx = m ? ex2_dr : pa_dr;
      ex2_dr: nx = m ? up_dr : sh_dr;
      up_dr: nx = m ? sel_dr : rti;
      sel_ir: nx = m ? tlr : cap_ir;
      cap_ir: nx = m ? ex1_ir : sh_ir;
      sh_ir: nx = m ? ex1_ir : sh_ir;
      ex1_ir: nx = m ? up_ir : pa_ir;
      pa_ir: nx = m ? ex2_ir : pa_ir;
      ex2_ir: nx = m ? up_ir : sh_ir;
      default: nx = m ? sel_dr : rti;
    endcase
  endfunction : nx

  initial state = tlr;

  always @(posedge tck_l) begin
    state <= nx(state, tms_l);
    if (state == sh_dr) begin
      q <= tdi_l;
    end
  end

  // Outside shifting the output is not driven, so show a changed level.
  assign tdo = (state == sh_dr) ? q : ~q;
endmodule : jlp_chain_model

// file: testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import jlp_pkg::*;

  // Identification value is arbitrary.
  localparam logic [31:0] tb_id = 32'h5a5a0001;
  localparam logic [7:0] rc [4] = '{mode_select_instr, group_select_instr,
    signature_select_instr, counter_select_instr};
  localparam int rw [4] = '{8, 2, 16, 32};
  localparam logic [31:0] rv [4] = '{chain_mode_reset, multicast_group_reset,
    signature_compactor_reset, test_clock_countdown_reset};
  logic ref_clk;
  logic rst = 1'b1;
  jlp_pins_type pins;
  jlp_pins_type pins_in;
  logic [jlp_ports-1:0] tdo_r;
  logic tdob;
  logic tdob_oe_n;
  jlp_lport_type [jlp_ports-1:0] lport;
  jlp_tap_type lst [jlp_ports];
  logic [jlp_ports-1:0] tdo_l;
  logic [2:0] ck_or;
  logic [31:0] rd;
  int n_mismatch = 0;
  int check_count = 0;

  jlp_bridge #(.id_code(tb_id)) DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .pins(pins_in),
    .tdob(tdob),
    .tdob_oe_n(tdob_oe_n),
    .lport(lport)
  );

  for (genvar i = 0; i < jlp_ports; i++) begin : g_ch
    jlp_chain_model u_ch (
      .tck_l(lport[i].local_test_clock),
      .tms_l(lport[i].local_mode_select),
      .tdi_l(lport[i].local_tdi_out),
      .tdo(tdo_l[i]),
      .state(lst[i])
    );
  end

  always @(posedge ref_clk) tdo_r <= tdo_l;

  // Returning chain data has its own process, so the bundle is joined here.
  assign pins_in = {pins.backplane_test_clock, pins.backplane_mode_select,
    pins.backplane_tdi, pins.test_reset_n, tdo_r};

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [2:0] ms();
    ms = {lport[2].local_mode_select, lport[1].local_mode_select,
      lport[0].local_mode_select};
  endfunction : ms

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask : chk

  // Sampling on the falling system edge keeps clear of register updates.
  task automatic w(int n);
    repeat (n) begin
      @(negedge ref_clk);
      ck_or |= {lport[2].local_test_clock, lport[1].local_test_clock,
        lport[0].local_test_clock};
    end
  endtask : w

  // Mode select and data move mid high phase, well clear of both edges.
  task automatic tck(input logic tms, input logic tdi, output logic tdo);
    @(posedge ref_clk);
    pins.backplane_mode_select <= tms;
    pins.backplane_tdi <= tdi;
    w(4);
    @(posedge ref_clk);
    pins.backplane_test_clock <= 1'b0;
    w(8);
    tdo = tdob;
    @(posedge ref_clk);
    pins.backplane_test_clock <= 1'b1;
    w(4);
  endtask : tck

  task automatic idle(int n, logic tms = 1'b0);
    logic d;
    repeat (n) tck(tms, 1'b0, d);
  endtask : idle

  task automatic ir(logic [7:0] c, logic nt);
    logic d;
    idle(2, 1'b1);
    idle(2);
    for (int i = 0; i < 8; i++) tck(i == 7, c[i], d);
    idle(1, 1'b1);
    idle(1, nt);
  endtask : ir

  task automatic dr(int n, logic [31:0] v, output logic [31:0] o);
    logic d;
    o = '0;
    idle(1, 1'b1);
    idle(2);
    for (int i = 0; i < n; i++) begin
      tck(i == n - 1, v[i], d);
      o[i] = d;
      if (i == 0) begin
        chk("tdo enable", tdob_oe_n, 1'b0);
      end
    end
    idle(1, 1'b1);
    idle(1);
  endtask : dr

  task automatic clk_meas();
    idle(1);
    ck_or = '0;
    idle(2);
  endtask : clk_meas

  task automatic tend(string s);
    $display("test %s finished", s);
  endtask : tend

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////

  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end

  initial begin
    pins = '0;
    pins.test_reset_n = 1'b1;
    ck_or = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    w(1);
    chk("local mode select", ms(), 3'h7);
    chk("tdo idle", tdob_oe_n, 1'b1);
    idle(1);
    dr(32, 32'h0, rd);
    chk("idcode", rd, tb_id);
    for (int i = 0; i < 4; i++) begin
      ir(rc[i], 1'b0);
      dr(rw[i], rv[i], rd);
      chk("reset value", rd, rv[i]);
    end
    tend("reset values");
    ir(mode_select_instr, 1'b0);
    dr(8, 32'hff, rd);
    clk_meas();
    chk("stopped clocks", ck_or, 3'h0);
    dr(8, 32'h00, rd);
    chk("mode", rd, mode_write_mask);
    clk_meas();
    chk("running clocks", ck_or, 3'h7);
    tend("clock stop");
    ir(counter_enable_instr, 1'b0);
    ir(park_idle_instr, 1'b0);
    ir(counter_select_instr, 1'b0);
    dr(32, 32'h3c, rd);
    ir(mode_select_instr, 1'b0);
    dr(8, 32'h00, rd);
    chk("done flag", rd[7], 1'b0);
    idle(60);
    dr(8, 32'h00, rd);
    chk("done flag", rd[7], 1'b1);
    clk_meas();
    chk("terminal clocks", ck_or, 3'h0);
    ir(counter_select_instr, 1'b0);
    dr(32, 32'h0, rd);
    chk("count", rd, 32'h0);
    ir(counter_disable_instr, 1'b0);
    clk_meas();
    chk("clocks after disable", ck_or, 3'h7);
    tend("self test");
    ir(mode_select_instr, 1'b0);
    dr(8, 32'h17, rd);
    ir(unpark_instr, 1'b0);
    idle(1);
    chk("loopback park", ms(), 3'h7);
    ir(mode_select_instr, 1'b0);
    dr(8, 32'h05, rd);
    ir(unpark_instr, 1'b1);
    idle(1);
    chk("unpark low", ms(), 3'h2);
    chk("local idle", lst[0], rti);
    for (int i = 0; i < 2; i++) begin
      idle(1, 1'b1);
      chk("waiting low", ms(), 3'h2);
    end
    idle(1);
    idle(1, 1'b1);
    chk("follow", ms(), 3'h7);
    idle(1);
    idle(2, 1'b1);
    idle(1);
    chk("sync port 0", lst[0], rti);
    chk("sync port 2", lst[2], rti);
    chk("parked port 1", lst[1], tlr);
    tend("unpark");
    ir(park_pause_instr, 1'b0);
    idle(1, 1'b1);
    idle(1);
    idle(1, 1'b1);
    idle(1);
    chk("pause park", lst[0], pa_dr);
    idle(2, 1'b1);
    idle(1);
    chk("pause held", ms(), 3'h2);
    ir(unpark_instr, 1'b0);
    idle(1, 1'b1);
    idle(1);
    idle(1, 1'b1);
    chk("pause waiting", lst[2], pa_dr);
    idle(1);
    idle(2, 1'b1);
    idle(1);
    chk("pause sync", lst[0], rti);
    ir(park_idle_instr, 1'b0);
    idle(1);
    chk("idle park", ms(), 3'h2);
    ir(park_reset_instr, 1'b0);
    idle(1);
    chk("reset park refused", ms(), 3'h2);
    chk("idle parked port", lst[0], rti);
    tend("park states");
    ir(local_soft_reset_instr, 1'b0);
    idle(5);
    chk("soft reset", ms(), 3'h7);
    for (int i = 0; i < jlp_ports; i++) begin
      chk("local reset", lst[i], tlr);
    end
    tend("soft reset");
    for (int k = 0; k < 2; k++) begin
      ir(mode_select_instr, 1'b0);
      dr(8, 32'h02, rd);
      ir(unpark_instr, 1'b0);
      idle(1);
      chk("unparked port", ms(), 3'h5);
      if (k == 0) begin
        idle(5, 1'b1);
        w(2);
      end else begin
        @(posedge ref_clk);
        pins.test_reset_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        pins.test_reset_n <= 1'b1;
        w(4);
      end
      chk("reset park", ms(), 3'h7);
      idle(1);
      dr(32, 32'h0, rd);
      chk("reset idcode", rd, tb_id);
      ir(mode_select_instr, 1'b0);
      dr(8, 32'h00, rd);
      chk("reset mode", rd, chain_mode_reset);
    end
    tend("controller reset");
    test_done();
  end
endmodule : tb
